// *** dv/uhpe_dev_model.sv ***
`timescale 1ns/1ps

module uhpe_dev_model #(
    parameter int NUM_PIPES = 2,
    parameter int SLOW_DLY  = 40
) (
    // clock
    input  wire logic                 clk,
    // far side control
    input  wire logic                 attach,
    input  wire logic                 slow,
    // link
    input  wire logic [NUM_PIPES-1:0] in_token,
    output logic                      dev_connected,
    output logic [NUM_PIPES-1:0]      in_ack
);
    int wait_cnt [NUM_PIPES];
    int hold_cnt [NUM_PIPES];

    initial begin
        dev_connected = 1'b0;
        in_ack = '0;
        for (int p = 0; p < NUM_PIPES; p++) begin
            wait_cnt[p] = 0;
            hold_cnt[p] = 0;
        end
    end

    // ack held two cycles so the host sync flops see a clean edge
    always @(posedge clk) begin
        dev_connected <= attach;
        for (int p = 0; p < NUM_PIPES; p++) begin
            if (in_token[p] && attach) begin
                wait_cnt[p] = slow ? SLOW_DLY + p : 1 + p;
            end else if (wait_cnt[p] > 0) begin
                wait_cnt[p]--;
                if (wait_cnt[p] == 0 && attach) hold_cnt[p] = 2;
            end
            in_ack[p] <= (hold_cnt[p] > 0);
            if (hold_cnt[p] > 0) hold_cnt[p]--;
        end
    end
endmodule // uhpe_dev_model

// *** dv/usb_host_pipe_errata_behaviour_tb_top.sv ***
`timescale 1ns/1ps
`include "uhpe_cfg.svh"

module usb_host_pipe_errata_behaviour_tb_top;
    localparam int NP    = 2;
    // long enough that low speed frame length high reaches 21
    localparam int FRAME = 11264;

    logic            REF_CLK = 1'b0;
    logic            RST_N = 1'b0;
    logic [7:0]      ADDR = 8'h00;
    logic [31:0]     WDATA = 32'h0;
    logic            WR = 1'b0;
    logic            RD = 1'b0;
    logic [31:0]     RDATA;
    logic            DEV_CONNECTED;
    logic [NP-1:0]   IN_ACK;
    logic [NP-1:0]   IN_TOKEN;
    logic            SOF_OUT;
    logic            RESUME_OUT;
    logic            SUSPEND;
    logic            attach = 1'b0;
    logic            slow = 1'b0;
    logic [31:0]     rv;
    logic [NP-1:0]   tok_seen;
    int              n_mismatch = 0;
    int              n_checks = 0;
    int              n_resume = 0;
    int              exp_cnt [NP];
    int              cnt;
    int              psz;
    int              mp;

    always #4 REF_CLK = ~REF_CLK;

    uhpe_top #(.NUM_PIPES(NP), .FRAME_CYCLES(FRAME)) u_dut (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .DEV_CONNECTED(DEV_CONNECTED), .IN_ACK(IN_ACK),
        .IN_TOKEN(IN_TOKEN), .SOF_OUT(SOF_OUT), .RESUME_OUT(RESUME_OUT), .SUSPEND(SUSPEND));

    uhpe_dev_model #(.NUM_PIPES(NP)) u_dev (
        .clk(REF_CLK), .attach(attach), .slow(slow), .in_token(IN_TOKEN),
        .dev_connected(DEV_CONNECTED), .in_ack(IN_ACK));

    always @(posedge REF_CLK) begin
        if (RST_N && RESUME_OUT !== 1'b0) n_resume++;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic wait_sof();
        for (int i = 0; i < FRAME + 200; i++) begin
            @(posedge REF_CLK);
            #1;
            if (SOF_OUT === 1'b1) break;
        end
        chk("sof pulse", 32'h1, {31'h0, SOF_OUT});
        // in tokens trail the sof pulse by one cycle
        @(posedge REF_CLK);
        #1;
        tok_seen = IN_TOKEN;
    endtask

    // sel 0: frame length high at least target, 1: detect state, 2: below target
    task automatic poll_state(input int sel, input int target);
        logic [31:0] s;
        for (int i = 0; i < 4000; i++) begin
            rd(`UHPE_OFS_STATE, s);
            if (sel == 0 && s[7:0] >= target) break;
            if (sel == 1 && s[9:8] == target) break;
            if (sel == 2 && s[7:0] < target) break;
        end
        chk("state poll", 32'h1, (sel == 0) ? (s[7:0] >= target) :
                                 (sel == 1) ? (s[9:8] == target) : (s[7:0] < target));
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge REF_CLK);
        n_mismatch++;
        $display("mismatch watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        void'($urandom(52));
        repeat (12) @(posedge REF_CLK);
        RST_N <= 1'b1;
        rd(`UHPE_OFS_CTRL, rv);
        chk("ctrl reset", 32'h0, rv);
        rd(`UHPE_OFS_PIPE_SIZE, rv);
        chk("pipe size reset", 32'h40, rv);
        rd(`UHPE_OFS_FLAGS, rv);
        chk("flags reset", 32'h0, rv);
        wr(8'hFC, 32'hFFFFFFFF);
        rd(8'hFC, rv);
        chk("unmapped read", 32'h0, rv);
        rd(`UHPE_OFS_CTRL, rv);
        chk("ctrl after unmapped write", 32'h0, rv);
        for (int k = 0; k < 8; k++) begin
            cnt = $urandom & 32'h1FF;
            psz = 1 + ($urandom % 255);
            mp = $urandom & 32'hFFFF;
            wr(`UHPE_OFS_PIPE_SIZE, psz);
            wr(8'h10 + 8'(8 * (k % 2)), cnt);
            wr(8'h14 + 8'(8 * (k % 2)), mp);
            rd(8'h10 + 8'(8 * (k % 2)), rv);
            chk("in request count", cnt & 32'hFF, rv);
            rd(8'h14 + 8'(8 * (k % 2)), rv);
            chk("mp size", (mp < (cnt & 255) * psz) ? mp : (cnt & 255) * psz, rv);
        end
        // counts kept below the packet counts of the transfers
        // counts only load while enabled, sof still off
        wr(`UHPE_OFS_CTRL, 32'h1);
        wr(`UHPE_OFS_PIPE_SIZE, 32'h40);
        wr(8'h10, 32'h2);
        wr(8'h14, 32'h200);
        wr(8'h18, 32'h1);
        wr(8'h1C, 32'h100);
        exp_cnt[0] = 2;
        exp_cnt[1] = 1;
        attach <= 1'b1;
        slow <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        wr(`UHPE_OFS_CTRL, 32'h7);
        for (int f = 0; f < 2; f++) begin
            wait_sof();
            chk("in tokens", {30'h0, exp_cnt[1] > 0, exp_cnt[0] > 0}, tok_seen);
            for (int p = 0; p < NP; p++) if (exp_cnt[p] > 0) exp_cnt[p]--;
            slow <= 1'b0;
        end
        rd(`UHPE_OFS_CTRL, rv);
        chk("resume bit stored", 32'h7, rv);
        chk("resume output pulses", 32'h0, n_resume);
        wr(8'h10, 32'h3);
        repeat (2) @(posedge REF_CLK);
        attach <= 1'b0;
        repeat (10) @(posedge REF_CLK);
        rd(`UHPE_OFS_FLAGS, rv);
        chk("disconnect flag", 32'h1, {31'h0, rv[0]});
        rd(`UHPE_OFS_STATE, rv);
        chk("pipes locked", 32'h1, {31'h0, rv[10]});
        attach <= 1'b1;
        wait_sof();
        chk("tokens while locked", 32'h0, tok_seen);
        wr(`UHPE_OFS_CTRL, 32'h0);
        wr(`UHPE_OFS_CTRL, 32'h3);
        wr(`UHPE_OFS_FLAGS, 32'hF);
        rd(`UHPE_OFS_STATE, rv);
        chk("lock cleared", 32'h0, {31'h0, rv[10]});
        wr(8'h10, 32'h1);
        wait_sof();
        chk("tokens after recovery", 32'h1, tok_seen);
        // late sof disable in low speed
        wr(`UHPE_OFS_CTRL, 32'h13);
        wr(`UHPE_OFS_FLAGS, 32'hF);
        wait_sof();
        poll_state(0, 21);
        wr(`UHPE_OFS_CTRL, 32'h11);
        rd(`UHPE_OFS_FLAGS, rv);
        chk("late sof disable fails", 32'h1, {31'h0, rv[2]});
        repeat (400) @(posedge REF_CLK);
        chk("no suspend after fail", 32'h0, {31'h0, SUSPEND});
        // freeze during detect state three
        wr(`UHPE_OFS_FLAGS, 32'hF);
        wr(`UHPE_OFS_CTRL, 32'h13);
        wait_sof();
        poll_state(2, 21);
        wr(`UHPE_OFS_CTRL, 32'h11);
        poll_state(1, 3);
        wr(`UHPE_OFS_CTRL, 32'h19);
        rd(`UHPE_OFS_FLAGS, rv);
        chk("freeze in state three", 32'h4, rv & 32'hC);
        // compliant suspend entry
        wr(`UHPE_OFS_FLAGS, 32'hF);
        wr(`UHPE_OFS_CTRL, 32'h13);
        wait_sof();
        poll_state(2, 21);
        wr(`UHPE_OFS_CTRL, 32'h11);
        repeat (400) @(posedge REF_CLK);
        chk("suspend entered", 32'h1, {31'h0, SUSPEND});
        rd(`UHPE_OFS_STATE, rv);
        chk("detect idle", 32'h0, {30'h0, rv[9:8]});
        wr(`UHPE_OFS_CTRL, 32'h19);
        rd(`UHPE_OFS_FLAGS, rv);
        chk("clean freeze", 32'h8, rv & 32'hC);
        end_of_test();
    end
endmodule // usb_host_pipe_errata_behaviour_tb_top

// *** src/uhpe_cfg.svh ***
`ifndef UHPE_CFG_SVH
`define UHPE_CFG_SVH

// register byte offsets
`define UHPE_ADDR_W          8
`define UHPE_OFS_CTRL        8'h00
`define UHPE_OFS_FLAGS       8'h04
`define UHPE_OFS_STATE       8'h08
`define UHPE_OFS_PIPE_SIZE   8'h0C
`define UHPE_OFS_PIPE_BASE   8'h10
`define UHPE_PIPE_STRIDE     8'h08
`define UHPE_OFS_PIPE_MP     8'h04

// control bit positions
`define UHPE_CTRL_ENABLE     0
`define UHPE_CTRL_SOF_EN     1
`define UHPE_CTRL_RESUME     2
`define UHPE_CTRL_FREEZE     3
`define UHPE_CTRL_LOW_SPEED  4

// flag bit positions
`define UHPE_FLG_DISCONNECT  0
`define UHPE_FLG_SOF         1
`define UHPE_FLG_SUSP_FAIL   2
`define UHPE_FLG_SUSPENDED   3

// state register fields
`define UHPE_ST_FLEN_LSB     0
`define UHPE_ST_DET_LSB      8
`define UHPE_ST_LOCKED       10

// reset values and limits
`define UHPE_PIPE_SIZE_RST   10'h040
`define UHPE_FLEN_LIMIT_FS   8'd185
`define UHPE_FLEN_LIMIT_LS   8'd21
`define UHPE_DET_STATE_HAZ   2'd3

// timing
`define UHPE_CLK_PERIOD_NS   8
`define UHPE_FRAME_NS        1000000
`define UHPE_DET_STEP_NS     1000
`define UHPE_FLEN_SHIFT      9

`endif

// *** src/uhpe_pipe.sv ***
`timescale 1ns/1ps
`include "uhpe_cfg.svh"

module uhpe_pipe #(
    parameter int CNT_W  = 8,
    parameter int SIZE_W = 10,
    parameter int MP_W   = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // control
    input  wire logic              enable,
    input  wire logic              locked,
    input  wire logic              load,
    input  wire logic [CNT_W-1:0]  request_count,
    input  wire logic [MP_W-1:0]   mp_size,
    input  wire logic [SIZE_W-1:0] pipe_size,
    // link events
    input  wire logic              sof,
    input  wire logic              in_ack,
    // results
    output logic                   token,
    output logic                   busy,
    output logic [MP_W-1:0]        eff_size
);
    if (CNT_W < 1 || SIZE_W < 1 || MP_W < CNT_W) begin : g_chk
        $error("uhpe_pipe: unsupported widths");
    end

    logic [CNT_W-1:0]        remaining;
    logic [CNT_W-1:0]        next_remaining;
    logic                    next_token;
    logic [CNT_W+SIZE_W-1:0] cap;

    // product kept at full width, so no launch count can wrap the cap
    assign cap      = CNT_W'(request_count) * (CNT_W+SIZE_W)'(pipe_size);
    assign eff_size = ((CNT_W+SIZE_W)'(mp_size) > cap) ? MP_W'(cap) : mp_size;
    assign busy     = (remaining != '0);

    always_comb begin
        next_remaining = remaining;
        next_token     = 1'b0;
        if (!enable) begin
            next_remaining = '0;
        end else if (load) begin
            next_remaining = request_count;
        end else if (in_ack && busy) begin
            next_remaining = remaining - CNT_W'(1);
        end
        if (enable && sof && busy && !locked) begin
            next_token = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remaining <= '0;
            token     <= 1'b0;
        end else begin
            remaining <= next_remaining;
            token     <= next_token;
        end
    end

    a_count_loads: assert property (@(posedge clk) disable iff (!rst_n)
        enable && load |=> remaining == $past(request_count))
        else $error("in request count not loaded");
    a_size_capped: assert property (@(posedge clk) disable iff (!rst_n)
        (CNT_W+SIZE_W)'(eff_size) <= cap && eff_size <= mp_size
        && ((CNT_W+SIZE_W)'(eff_size) == cap || eff_size == mp_size))
        else $error("multi-packet size not capped");
    a_token_locked: assert property (@(posedge clk) disable iff (!rst_n)
        token |-> !$past(locked) && $past(busy))
        else $error("token issued on locked or idle pipe");

endmodule // uhpe_pipe

// *** src/uhpe_pkg.sv ***
package uhpe_pkg;

    typedef enum logic [3:0] {
        DET_IDLE = 4'b0001,
        DET_ONE  = 4'b0010,
        DET_TWO  = 4'b0100,
        DET_HAZ  = 4'b1000
    } uhpe_det_t;

    typedef struct packed {
        logic low_speed;
        logic clock_freeze;
        logic host_resume_request;
        logic sof_generation_enable;
        logic controller_enable;
    } uhpe_ctrl_t;

    typedef struct packed {
        logic suspended;
        logic suspend_fail;
        logic host_sof_flag;
        logic device_disconnect_flag;
    } uhpe_flags_t;

endpackage

// *** src/uhpe_top.sv ***
`timescale 1ns/1ps
`include "uhpe_cfg.svh"

module uhpe_top #(
    parameter int NUM_PIPES    = 2,
    parameter int CNT_W        = 8,
    parameter int SIZE_W       = 10,
    parameter int MP_W         = 16,
    parameter int FRAME_CYCLES = `UHPE_FRAME_NS / `UHPE_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    // register port
    input  wire logic [`UHPE_ADDR_W-1:0] ADDR,
    input  wire logic [31:0]          WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic [31:0]               RDATA,
    // link side
    input  wire logic                 DEV_CONNECTED,
    input  wire logic [NUM_PIPES-1:0] IN_ACK,
    output logic [NUM_PIPES-1:0]      IN_TOKEN,
    output logic                      SOF_OUT,
    output logic                      RESUME_OUT,
    output logic                      SUSPEND
);
    localparam int DET_STEP_CYC = (`UHPE_DET_STEP_NS + `UHPE_CLK_PERIOD_NS - 1)
                                  / `UHPE_CLK_PERIOD_NS;
    localparam int FRM_W = $clog2(FRAME_CYCLES + 1);
    localparam int DET_W = $clog2(DET_STEP_CYC + 1);

    if (NUM_PIPES < 1 || NUM_PIPES > 16 || CNT_W != 8 || FRAME_CYCLES < 2) begin : g_chk
        $error("uhpe_top: unsupported parameters");
    end

    uhpe_pkg::uhpe_ctrl_t  ctrl, next_ctrl;
    uhpe_pkg::uhpe_flags_t flags, next_flags;
    uhpe_pkg::uhpe_det_t   det, next_det;
    logic [SIZE_W-1:0]     pipe_size, next_pipe_size;
    logic [CNT_W-1:0]      req_cnt [NUM_PIPES];
    logic [MP_W-1:0]       mp_size [NUM_PIPES];
    logic [MP_W-1:0]       eff_size [NUM_PIPES];
    logic [NUM_PIPES-1:0]  busy, token, load, ack_edge;
    logic [NUM_PIPES-1:0]  ack_s1, ack_s2, ack_s3;
    logic                  conn_s1, conn_s2, conn_s3;
    logic                  locked, next_locked;
    logic [FRM_W-1:0]      frame_cnt, next_frame_cnt;
    logic [DET_W-1:0]      det_cnt, next_det_cnt;
    logic                  sof_pulse, next_sof_pulse;
    logic [31:0]           next_rdata;
    logic [7:0]            flen_high, flen_limit;
    logic [1:0]            det_num;
    logic                  disconnect, clk_run, sof_off, freeze_on, late_sof, haz_frz;
    logic                  wr_ctrl;

    // two-stage synchronisers; third stage only for edge detection
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {conn_s1, conn_s2, conn_s3} <= 3'h0;
            {ack_s1, ack_s2, ack_s3}    <= '0;
        end else begin
            conn_s1 <= DEV_CONNECTED;
            conn_s2 <= conn_s1;
            conn_s3 <= conn_s2;
            ack_s1  <= IN_ACK;
            ack_s2  <= ack_s1;
            ack_s3  <= ack_s2;
        end
    end

    assign disconnect = conn_s3 && !conn_s2;
    assign ack_edge   = ack_s2 & ~ack_s3;
    assign clk_run    = ctrl.controller_enable && !ctrl.clock_freeze;
    assign flen_high  = 8'(frame_cnt >> `UHPE_FLEN_SHIFT);
    assign flen_limit = ctrl.low_speed ? `UHPE_FLEN_LIMIT_LS : `UHPE_FLEN_LIMIT_FS;
    assign wr_ctrl    = WR && ADDR == `UHPE_OFS_CTRL;
    assign sof_off    = wr_ctrl && ctrl.sof_generation_enable
                        && !WDATA[`UHPE_CTRL_SOF_EN];
    assign freeze_on  = wr_ctrl && !ctrl.clock_freeze && WDATA[`UHPE_CTRL_FREEZE];
    // sof disabled too soon after a flagged sof
    assign late_sof   = sof_off && flags.host_sof_flag && flen_high >= flen_limit;
    // freezing in low speed while detection sits in its last state
    assign haz_frz    = freeze_on && ctrl.low_speed && det == uhpe_pkg::DET_HAZ;

    always_comb begin
        case (det)
            uhpe_pkg::DET_ONE: det_num = 2'd1;
            uhpe_pkg::DET_TWO: det_num = 2'd2;
            uhpe_pkg::DET_HAZ: det_num = `UHPE_DET_STATE_HAZ;
            default:           det_num = 2'd0;
        endcase
    end

    // per-pipe request counters and descriptor sizes
    for (genvar p = 0; p < NUM_PIPES; p++) begin : g_pipe
        localparam logic [`UHPE_ADDR_W-1:0] BASE =
            `UHPE_ADDR_W'(`UHPE_OFS_PIPE_BASE + p * `UHPE_PIPE_STRIDE);
        logic [CNT_W-1:0] next_req;
        logic [MP_W-1:0]  next_mp;
        logic             load_q;

        assign load[p] = WR && ADDR == BASE;
        always_comb begin
            next_req = req_cnt[p];
            next_mp  = mp_size[p];
            if (load[p]) begin
                next_req = WDATA[CNT_W-1:0];
            end
            if (WR && ADDR == BASE + `UHPE_OFS_PIPE_MP) begin
                next_mp = WDATA[MP_W-1:0];
            end
        end
        always_ff @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
                req_cnt[p] <= '0;
                mp_size[p] <= '0;
                load_q     <= 1'b0;
            end else begin
                req_cnt[p] <= next_req;
                mp_size[p] <= next_mp;
                load_q     <= load[p];
            end
        end

        uhpe_pipe #(.CNT_W(CNT_W), .SIZE_W(SIZE_W), .MP_W(MP_W)) u_pipe (
            .clk           (REF_CLK),
            .rst_n         (RST_N),
            .enable        (ctrl.controller_enable),
            .locked        (locked),
            // pipe reloads a cycle late, from the stored count, so the cap
            // never follows whatever happens to sit on the write data bus
            .load          (load_q),
            .request_count (req_cnt[p]),
            .mp_size       (mp_size[p]),
            .pipe_size     (pipe_size),
            .sof           (sof_pulse),
            .in_ack        (ack_edge[p]),
            .token         (token[p]),
            .busy          (busy[p]),
            .eff_size      (eff_size[p])
        );
    end

    always_comb begin
        next_ctrl      = ctrl;
        next_pipe_size = pipe_size;
        next_flags     = flags;
        next_locked    = locked;
        next_frame_cnt = frame_cnt;
        next_sof_pulse = 1'b0;
        next_det       = det;
        next_det_cnt   = det_cnt;
        next_rdata     = 32'h0;
        if (wr_ctrl) begin
            // resume request is stored but drives nothing
            next_ctrl = uhpe_pkg::uhpe_ctrl_t'(WDATA[`UHPE_CTRL_LOW_SPEED:0]);
        end
        if (WR && ADDR == `UHPE_OFS_PIPE_SIZE) begin
            next_pipe_size = WDATA[SIZE_W-1:0];
        end
        // software clears by writing one; a same-cycle event wins
        if (WR && ADDR == `UHPE_OFS_FLAGS) begin
            next_flags = flags & ~uhpe_pkg::uhpe_flags_t'(WDATA[`UHPE_FLG_SUSPENDED:0]);
        end
        if (ctrl.controller_enable && disconnect) begin
            next_flags.device_disconnect_flag = 1'b1;
            if (|busy) begin
                next_locked = 1'b1;
            end
        end
        // only a pass through disabled clears the lock
        if (!ctrl.controller_enable) begin
            next_locked = 1'b0;
        end
        if (clk_run && ctrl.sof_generation_enable) begin
            if (frame_cnt == '0) begin
                next_frame_cnt = FRM_W'(FRAME_CYCLES - 1);
                next_sof_pulse = 1'b1;
                next_flags.host_sof_flag = 1'b1;
                next_flags.suspended = 1'b0;
            end else begin
                next_frame_cnt = frame_cnt - FRM_W'(1);
            end
        end
        if (late_sof || haz_frz) begin
            next_flags.suspend_fail = 1'b1;
            next_det = uhpe_pkg::DET_IDLE;
            next_det_cnt = '0;
        end else if (sof_off && ctrl.controller_enable) begin
            next_det = uhpe_pkg::DET_ONE;
            next_det_cnt = '0;
        end else if (clk_run && det != uhpe_pkg::DET_IDLE) begin
            // detection stalls while the controller clock is frozen
            if (det_cnt == DET_W'(DET_STEP_CYC - 1)) begin
                next_det_cnt = '0;
                case (det)
                    uhpe_pkg::DET_ONE: next_det = uhpe_pkg::DET_TWO;
                    uhpe_pkg::DET_TWO: next_det = uhpe_pkg::DET_HAZ;
                    uhpe_pkg::DET_HAZ: begin
                        next_det = uhpe_pkg::DET_IDLE;
                        next_flags.suspended = 1'b1;
                    end
                    default:           next_det = uhpe_pkg::DET_IDLE;
                endcase
            end else begin
                next_det_cnt = det_cnt + DET_W'(1);
            end
        end
        if (!ctrl.controller_enable) begin
            next_frame_cnt = '0;
            next_det = uhpe_pkg::DET_IDLE;
        end
        if (RD) begin
            if (ADDR == `UHPE_OFS_CTRL) begin
                next_rdata = 32'(ctrl);
            end else if (ADDR == `UHPE_OFS_FLAGS) begin
                next_rdata = 32'(flags);
            end else if (ADDR == `UHPE_OFS_STATE) begin
                next_rdata[`UHPE_ST_FLEN_LSB +: 8] = flen_high;
                next_rdata[`UHPE_ST_DET_LSB +: 2]  = det_num;
                next_rdata[`UHPE_ST_LOCKED]        = locked;
            end else if (ADDR == `UHPE_OFS_PIPE_SIZE) begin
                next_rdata = 32'(pipe_size);
            end
            for (int i = 0; i < NUM_PIPES; i++) begin
                if (ADDR == `UHPE_ADDR_W'(`UHPE_OFS_PIPE_BASE + i * `UHPE_PIPE_STRIDE)) begin
                    next_rdata = 32'(req_cnt[i]);
                end
                if (ADDR == `UHPE_ADDR_W'(`UHPE_OFS_PIPE_BASE + i * `UHPE_PIPE_STRIDE
                                         + `UHPE_OFS_PIPE_MP)) begin
                    next_rdata = 32'(eff_size[i]);
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl       <= '0;
            pipe_size  <= `UHPE_PIPE_SIZE_RST;
            flags      <= '0;
            locked     <= 1'b0;
            frame_cnt  <= '0;
            sof_pulse  <= 1'b0;
            det        <= uhpe_pkg::DET_IDLE;
            det_cnt    <= '0;
            RDATA      <= 32'h0;
            IN_TOKEN   <= '0;
            SOF_OUT    <= 1'b0;
            RESUME_OUT <= 1'b0;
            SUSPEND    <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            pipe_size  <= next_pipe_size;
            flags      <= next_flags;
            locked     <= next_locked;
            frame_cnt  <= next_frame_cnt;
            sof_pulse  <= next_sof_pulse;
            det        <= next_det;
            det_cnt    <= next_det_cnt;
            RDATA      <= next_rdata;
            IN_TOKEN   <= token;
            SOF_OUT    <= sof_pulse;
            RESUME_OUT <= 1'b0;
            SUSPEND    <= next_flags.suspended;
        end
    end

    sequence s_disc_busy;
        ctrl.controller_enable && disconnect && |busy;
    endsequence

    a_resume_dead: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_ctrl && WDATA[`UHPE_CTRL_RESUME] |=> (!RESUME_OUT) [*3])
        else $error("resume signalling produced");
    a_lock_on_disc: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        s_disc_busy |=> locked && flags.device_disconnect_flag)
        else $error("pipes not locked after disconnect");
    a_lock_holds: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        locked && ctrl.controller_enable |=> locked)
        else $error("lock released without controller reset");
    a_no_token_locked: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        locked ##1 locked |=> IN_TOKEN == '0)
        else $error("in token while locked");
    a_late_sof_fail: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        late_sof |=> flags.suspend_fail && det == uhpe_pkg::DET_IDLE ##1 !SUSPEND)
        else $error("late sof disable did not fail suspend");
    a_freeze_fail: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        haz_frz |=> flags.suspend_fail && det == uhpe_pkg::DET_IDLE)
        else $error("freeze in detect state three did not fail suspend");

endmodule // uhpe_top
